// ---- rtl/pfsre_params.svh ----
// Constants for the program flash self read/erase sequencer.
// Assumes a 20 MHz core clock and a 32-bit classic Wishbone slave port.
`ifndef PFSRE_PARAMS_SVH
`define PFSRE_PARAMS_SVH
// ==========================================================
// Register byte offsets
`define PFSRE_OFS_ADDR_LOW   6'h00
`define PFSRE_OFS_ADDR_HIGH  6'h04
`define PFSRE_OFS_DATA_LOW   6'h08
`define PFSRE_OFS_DATA_HIGH  6'h0c
`define PFSRE_OFS_CONTROL    6'h10
`define PFSRE_OFS_UNLOCK     6'h14
// ==========================================================
// Control register bit positions
`define PFSRE_BIT_PGM_SEL    7
`define PFSRE_BIT_ERASE_SEL  4
`define PFSRE_BIT_WR_EN      2
`define PFSRE_BIT_WR         1
`define PFSRE_BIT_RD         0
// ==========================================================
// Unlock keys and field sizes
`define PFSRE_KEY_FIRST      8'h55
`define PFSRE_KEY_SECOND     8'haa
`define PFSRE_BLK_LSB        5
`define PFSRE_SETUP_STEPS    2'h2
// ==========================================================
// Timing: erase time in microseconds, clock in MHz
`define PFSRE_ERASE_TIME_US  2000
`define PFSRE_CLK_MHZ        20
`define PFSRE_ERASE_CYCLES   (`PFSRE_ERASE_TIME_US * `PFSRE_CLK_MHZ)
`endif

// ---- rtl/pfsre_pkg.sv ----
// Types for the program flash self read/erase sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package pfsre_pkg;
   typedef enum logic [2:0] {
      PFSRE_IDLE,
      PFSRE_RD_WAIT,
      PFSRE_RD_ACCESS,
      PFSRE_ER_SETUP,
      PFSRE_ER_RUN
   } pfsre_state_e;
   typedef logic [13:0] pfsre_word_t;
   typedef logic [12:0] pfsre_addr_t;
endpackage
`default_nettype wire

// ---- rtl/pfsre_top.sv ----
// Program flash self read / block erase sequencer with Wishbone registers.
// Assumes flash array and core share clk_i; instr_step_i marks one
// instruction cycle; flash_rdata_i is valid while flash_rd_o is high.
`include "pfsre_params.svh"
`default_nettype none
module pfsre_top
   import pfsre_pkg::*;
#(
   parameter int ERASE_CYCLES = `PFSRE_ERASE_CYCLES
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [5:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output var  logic [31:0] wb_dat_o,
   output var  logic        wb_ack_o,
   input  wire logic        instr_step_i,
   input  wire pfsre_word_t flash_rdata_i,
   output var  logic        flash_rd_o,
   output var  logic        flash_erase_o,
   output var  pfsre_addr_t flash_addr_o,
   output var  logic        core_skip_o,
   output var  logic        core_stall_o
);
   // ==========================================================
   // Registers
   logic [7:0]   flash_addr_low;
   logic [4:0]   flash_addr_high;
   logic [7:0]   flash_data_low;
   logic [5:0]   flash_data_high;
   logic         program_space_select;
   logic         erase_select;
   logic         write_enable;
   logic         rd_bit;
   logic         wr_bit;
   logic [1:0]   unlock_stage;
   logic [1:0]   setup_cnt;
   logic [15:0]  erase_cnt;
   pfsre_state_e state;

   // ==========================================================
   // Bus decode
   wire req      = wb_cyc_i & wb_stb_i;
   wire commit   = ce_i & req & wb_ack_o & wb_we_i & wb_sel_i[0];
   wire [7:0] wbyte = wb_dat_i[7:0];

   function automatic logic hit(input logic [5:0] a, input logic [5:0] o);
      hit = (a == o);
   endfunction

   wire wr_alow  = commit & hit(wb_adr_i, `PFSRE_OFS_ADDR_LOW);
   wire wr_ahigh = commit & hit(wb_adr_i, `PFSRE_OFS_ADDR_HIGH);
   wire wr_dlow  = commit & hit(wb_adr_i, `PFSRE_OFS_DATA_LOW);
   wire wr_dhigh = commit & hit(wb_adr_i, `PFSRE_OFS_DATA_HIGH);
   wire wr_ctrl  = commit & hit(wb_adr_i, `PFSRE_OFS_CONTROL);
   wire wr_unlk  = commit & hit(wb_adr_i, `PFSRE_OFS_UNLOCK);

   wire [7:0] ctrl_rd = {program_space_select, 2'h0, erase_select,
                         1'b0, write_enable, wr_bit, rd_bit};
   wire [7:0] rd_mux =
      hit(wb_adr_i, `PFSRE_OFS_ADDR_LOW)  ? flash_addr_low :
      hit(wb_adr_i, `PFSRE_OFS_ADDR_HIGH) ? {3'h0, flash_addr_high} :
      hit(wb_adr_i, `PFSRE_OFS_DATA_LOW)  ? flash_data_low :
      hit(wb_adr_i, `PFSRE_OFS_DATA_HIGH) ? {2'h0, flash_data_high} :
      hit(wb_adr_i, `PFSRE_OFS_CONTROL)   ? ctrl_rd : 8'h00;

   // ==========================================================
   // Start conditions
   wire idle     = (state == PFSRE_IDLE);
   wire set_rd   = wr_ctrl & wbyte[`PFSRE_BIT_RD];
   wire set_wr   = wr_ctrl & wbyte[`PFSRE_BIT_WR];
   wire rd_go    = idle & set_rd & wbyte[`PFSRE_BIT_PGM_SEL];
   wire wr_go    = idle & ~rd_go & set_wr & (unlock_stage == 2'h2)
                 & wbyte[`PFSRE_BIT_WR_EN]
                 & wbyte[`PFSRE_BIT_PGM_SEL] & wbyte[`PFSRE_BIT_ERASE_SEL];
   wire rd_done  = (state == PFSRE_RD_ACCESS) & instr_step_i;
   wire er_done  = (state == PFSRE_ER_RUN)
                 & (erase_cnt == 16'(ERASE_CYCLES - 1));

   // ==========================================================
   // Wishbone answer, one cycle after the request appears
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else if (ce_i) begin
         wb_ack_o <= req & ~wb_ack_o;
         wb_dat_o <= {24'h00_0000, rd_mux};
      end
   end

   // ==========================================================
   // Address and data registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flash_addr_low  <= 8'h00;
         flash_addr_high <= 5'h00;
         flash_data_low  <= 8'h00;
         flash_data_high <= 6'h00;
      end else if (ce_i) begin
         if (wr_alow)  flash_addr_low  <= wbyte;
         if (wr_ahigh) flash_addr_high <= wbyte[4:0];
         if (rd_done) begin
            flash_data_low  <= flash_rdata_i[7:0];
            flash_data_high <= flash_rdata_i[13:8];
         end else begin
            if (wr_dlow)  flash_data_low  <= wbyte;
            if (wr_dhigh) flash_data_high <= wbyte[5:0];
         end
      end
   end

   // ==========================================================
   // Control bits; the set by rd_go/wr_go wins over the hardware clear, software cannot clear rd/wr
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         program_space_select <= 1'b0;
         erase_select         <= 1'b0;
         write_enable         <= 1'b0;
         rd_bit               <= 1'b0;
         wr_bit               <= 1'b0;
      end else if (ce_i) begin
         if (wr_ctrl) begin
            program_space_select <= wbyte[`PFSRE_BIT_PGM_SEL];
            erase_select         <= wbyte[`PFSRE_BIT_ERASE_SEL];
            write_enable         <= wbyte[`PFSRE_BIT_WR_EN];
         end
         if (rd_go)        rd_bit <= 1'b1;
         else if (rd_done) rd_bit <= 1'b0;
         if (wr_go)        wr_bit <= 1'b1;
         else if (er_done) wr_bit <= 1'b0;
      end
   end

   // ==========================================================
   // Unlock tracker: any other bus write with byte lane 0 enabled breaks the pair
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         unlock_stage <= 2'h0;
      end else if (ce_i && commit) begin
         if (wr_unlk && wbyte == `PFSRE_KEY_FIRST)
            unlock_stage <= 2'h1;
         else if (wr_unlk && wbyte == `PFSRE_KEY_SECOND
                  && unlock_stage == 2'h1)
            unlock_stage <= 2'h2;
         else
            unlock_stage <= 2'h0;
      end
   end

   // ==========================================================
   // Sequencer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state     <= PFSRE_IDLE;
         setup_cnt <= 2'h0;
         erase_cnt <= 16'h0000;
      end else if (ce_i) begin
         case (state)
            PFSRE_IDLE: begin
               setup_cnt <= 2'h0;
               erase_cnt <= 16'h0000;
               if (rd_go)      state <= PFSRE_RD_WAIT;
               else if (wr_go) state <= PFSRE_ER_SETUP;
            end
            PFSRE_RD_WAIT: begin
               if (instr_step_i) state <= PFSRE_RD_ACCESS;
            end
            PFSRE_RD_ACCESS: begin
               if (instr_step_i) state <= PFSRE_IDLE;
            end
            PFSRE_ER_SETUP: begin
               if (instr_step_i) begin
                  setup_cnt <= setup_cnt + 2'h1;
                  if (setup_cnt + 2'h1 == `PFSRE_SETUP_STEPS)
                     state <= PFSRE_ER_RUN;
               end
            end
            PFSRE_ER_RUN: begin
               erase_cnt <= erase_cnt + 16'h0001;
               if (er_done) state <= PFSRE_IDLE;
            end
            default: state <= PFSRE_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Registered outputs toward the array and the core
   wire nxt_access = (state == PFSRE_RD_WAIT & instr_step_i)
                   | (state == PFSRE_RD_ACCESS & ~instr_step_i);
   wire nxt_erase  = (state == PFSRE_ER_SETUP & instr_step_i
                      & (setup_cnt + 2'h1 == `PFSRE_SETUP_STEPS))
                   | (state == PFSRE_ER_RUN & ~er_done);
   wire nxt_go     = rd_go | wr_go;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flash_rd_o    <= 1'b0;
         flash_erase_o <= 1'b0;
         core_skip_o   <= 1'b0;
         core_stall_o  <= 1'b0;
         flash_addr_o  <= 13'h0000;
      end else if (ce_i) begin
         flash_rd_o    <= nxt_access;
         core_skip_o   <= nxt_access;
         flash_erase_o <= nxt_erase;
         core_stall_o  <= nxt_erase;
         if (nxt_go) begin
            flash_addr_o <= {flash_addr_high, flash_addr_low};
            if (wr_go)
               flash_addr_o[`PFSRE_BLK_LSB-1:0] <= 5'h00;
         end
      end
   end
endmodule
`default_nettype wire

// ---- testbench/pfsre_sva.sv ----
// Port checker for the flash self read/erase sequencer.
// Assumes ERASE_CYCLES matches the DUT; erase length counts only cycles
// with ce_i high, since the DUT freezes while it is low.
`default_nettype none
module pfsre_sva
   import pfsre_pkg::*;
#(
   parameter int ERASE_CYCLES = 8
) (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        ce_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [5:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        instr_step_i,
   input wire pfsre_word_t flash_rdata_i,
   input wire logic        flash_rd_o,
   input wire logic        flash_erase_o,
   input wire pfsre_addr_t flash_addr_o,
   input wire logic        core_skip_o,
   input wire logic        core_stall_o
);
   // ==========================================================
   // Erase length counter
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   int er_cnt;
   always_ff @(posedge clk_i) begin
      if (rst_i || !flash_erase_o) begin
         er_cnt <= 0;
      end else if (ce_i) begin
         er_cnt <= er_cnt + 1;
      end
   end
   sequence s_rd_start;
      $rose(flash_rd_o);
   endsequence
   sequence s_er_start;
      $rose(flash_erase_o);
   endsequence
   // ==========================================================
   // Properties
   property p_ack;
      wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o;
   endproperty
   property p_ack_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   property p_rd_skip;
      s_rd_start |-> core_skip_o && !core_stall_o;
   endproperty
   property p_rd_end;
      $fell(flash_rd_o) |-> $past(instr_step_i) && !core_skip_o;
   endproperty
   property p_er_start;
      s_er_start |-> $past(instr_step_i) && core_stall_o;
   endproperty
   property p_er_addr;
      flash_erase_o |-> flash_addr_o[4:0] == 5'h0 && !flash_rd_o;
   endproperty
   property p_er_len;
      $fell(flash_erase_o) |-> er_cnt == ERASE_CYCLES && !core_stall_o;
   endproperty
   property p_stall_tie;
      core_stall_o |-> flash_erase_o;
   endproperty
   a_ack: assert property (p_ack) else $error("no ack after request");
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
   a_rd_skip: assert property (p_rd_skip)
      else $error("read not skip");
   a_rd_end: assert property (p_rd_end)
      else $error("read end off");
   a_er_start: assert property (p_er_start)
      else $error("erase start");
   a_er_addr: assert property (p_er_addr)
      else $error("erase addr");
   a_er_len: assert property (p_er_len)
      else $error("erase length");
   a_stall_tie: assert property (p_stall_tie)
      else $error("stall");
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
// Self-checking bench for the flash self read/erase sequencer.
// Assumes the one-cycle Wishbone ack and instruction step pulses.
`include "pfsre_params.svh"
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int EC = 8;
   logic clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic instr_step_i, flash_rd_o, flash_erase_o, core_skip_o, core_stall_o;
   logic [5:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, q;
   logic [13:0] flash_rdata_i;
   logic [12:0] flash_addr_o;
   int fails = 0;
   int n_checks = 0;
   int i;
   pfsre_top #(.ERASE_CYCLES(EC)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
      .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .instr_step_i(instr_step_i), .flash_rdata_i(flash_rdata_i),
      .flash_rd_o(flash_rd_o), .flash_erase_o(flash_erase_o),
      .flash_addr_o(flash_addr_o), .core_skip_o(core_skip_o),
      .core_stall_o(core_stall_o));
   // ==========================================================
   // Tasks
   task automatic conclude();
      $display("checks=%0d mismatches=%0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One classic cycle; waits on ack, never on a fixed count
   task automatic wb(input logic w, input logic [5:0] a,
                     input logic [31:0] d);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (wb_ack_o !== 1'b1) begin
         fails++;
         conclude();
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      wb(1'b1, a, d);
   endtask
   task automatic rd(input logic [5:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(q, e);
   endtask
   task automatic step();
      @(posedge clk_i);
      instr_step_i <= 1'b1;
      @(posedge clk_i);
      instr_step_i <= 1'b0;
   endtask
   // ==========================================================
   // Clock and sequence
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   initial begin
      {rst_i, ce_i, wb_sel_i, flash_rdata_i} = {2'b11, 4'hf, 14'h2bcd};
      {wb_cyc_i, wb_stb_i, wb_we_i, instr_step_i} = 4'h0;
      {wb_adr_i, wb_dat_i} = '0;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      chk({flash_rd_o, flash_erase_o, core_skip_o, core_stall_o}, 32'h0);
      rd(6'h18, 32'h0);
      rd(`PFSRE_OFS_UNLOCK, 32'h0);
      wr(`PFSRE_OFS_ADDR_LOW, 32'h5a);
      wr(`PFSRE_OFS_ADDR_HIGH, 32'hf3);
      rd(`PFSRE_OFS_ADDR_HIGH, 32'h13);
      wr(`PFSRE_OFS_CONTROL, 32'h81);
      rd(`PFSRE_OFS_CONTROL, 32'h81);
      step();
      @(posedge clk_i);
      chk({flash_rd_o, core_skip_o, flash_addr_o},
          {2'b11, 13'h135a});
      step();
      flash_rdata_i <= 14'h0155;
      @(posedge clk_i);
      chk({flash_rd_o, core_skip_o}, 32'h0);
      rd(`PFSRE_OFS_DATA_LOW, 32'hcd);
      rd(`PFSRE_OFS_DATA_HIGH, 32'h2b);
      rd(`PFSRE_OFS_CONTROL, 32'h80);
      wr(`PFSRE_OFS_DATA_LOW, 32'h11);
      rd(`PFSRE_OFS_DATA_LOW, 32'h11);
      // Lane 0 off, or a write to a hole, must leave the data byte alone
      wb_sel_i <= 4'he;
      wr(`PFSRE_OFS_DATA_LOW, 32'h77);
      wb_sel_i <= 4'hf;
      wr(6'h18, 32'h77);
      rd(`PFSRE_OFS_DATA_LOW, 32'h11);
      // Write set refused: no unlock, then an unlock broken midway
      wr(`PFSRE_OFS_ADDR_LOW, 32'h5f);
      wr(`PFSRE_OFS_CONTROL, 32'h94);
      wr(`PFSRE_OFS_CONTROL, 32'h96);
      rd(`PFSRE_OFS_CONTROL, 32'h94);
      wr(`PFSRE_OFS_UNLOCK, 32'h55);
      wr(`PFSRE_OFS_ADDR_LOW, 32'h5f);
      wr(`PFSRE_OFS_UNLOCK, 32'haa);
      wr(`PFSRE_OFS_CONTROL, 32'h96);
      rd(`PFSRE_OFS_CONTROL, 32'h94);
      chk(flash_erase_o, 32'h0);
      wr(`PFSRE_OFS_UNLOCK, 32'h55);
      wr(`PFSRE_OFS_UNLOCK, 32'haa);
      wr(`PFSRE_OFS_CONTROL, 32'h96);
      rd(`PFSRE_OFS_CONTROL, 32'h96);
      step();
      chk(flash_erase_o, 32'h0);
      step();
      @(posedge clk_i);
      chk({flash_erase_o, core_stall_o, flash_addr_o},
          {2'b11, 13'h1340});
      // Three frozen cycles hold the stall; EC-1 enabled ones remain
      ce_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      ce_i <= 1'b1;
      chk({flash_erase_o, core_stall_o}, 32'h3);
      for (i = 0; i < 100 && flash_erase_o; i++) @(posedge clk_i);
      chk(i, EC);
      chk(core_stall_o, 32'h0);
      rd(`PFSRE_OFS_CONTROL, 32'h94);
      // Reset in mid-read drops the access and clears the registers
      wr(`PFSRE_OFS_CONTROL, 32'h81);
      step();
      @(posedge clk_i);
      chk({flash_rd_o, core_skip_o}, 32'h3);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      chk({flash_rd_o, core_skip_o, flash_addr_o}, 32'h0);
      rd(`PFSRE_OFS_CONTROL, 32'h0);
      rd(`PFSRE_OFS_ADDR_HIGH, 32'h0);
      conclude();
   end
endmodule
bind pfsre_top pfsre_sva #(.ERASE_CYCLES(ERASE_CYCLES)) u_sva (
   .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .instr_step_i(instr_step_i),
   .flash_rdata_i(flash_rdata_i), .flash_rd_o(flash_rd_o),
   .flash_erase_o(flash_erase_o), .flash_addr_o(flash_addr_o),
   .core_skip_o(core_skip_o), .core_stall_o(core_stall_o));
`default_nettype wire
